// File: rtl/pll_defines.svh
// Purpose: named offsets, fields, reset values and counts of the loop control block
// Assumes: byte addresses on a 32-bit register bus
// Notes:   included by the package, the checker and the bench
`ifndef PLL_DEFINES_SVH
`define PLL_DEFINES_SVH

// ****************************************************************
// bus
// ****************************************************************
`define AXI_AW          8
`define AXI_DW          32
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

// ****************************************************************
// register offsets
// ****************************************************************
`define OFF_LOOP_CTRL   8'h00
`define OFF_BW_CTRL     8'h04
`define OFF_MUL_PROG    8'h08

// ****************************************************************
// loop_control fields
// ****************************************************************
`define LC_IRQ_EN       7
`define LC_FLAG         6
`define LC_ENABLE       5
`define LC_SELECT       4
`define LC_ONES         4'hf

// ****************************************************************
// bandwidth_control fields
// ****************************************************************
`define BW_AUTO         7
`define BW_LOCK         6
`define BW_ACQ          5

// ****************************************************************
// multiplier_programming fields and reset values
// ****************************************************************
`define MP_N_HI         7
`define MP_N_LO         4
`define MP_L_HI         3
`define MP_L_LO         0
`define MP_FIELD_RST    4'h6
`define MP_ZERO         4'h0
`define MP_ONE          4'h1

// ****************************************************************
// source change: edges waited on each clock
// ****************************************************************
`define SW_EDGES        2'h3

`endif

// File: rtl/pll_pkg.sv
// Purpose: types shared by the loop control block and its bench
// Assumes: pll_defines.svh on the include path
// Notes:   bus signal names follow the published AXI4-Lite names
`include "pll_defines.svh"

package pll_pkg;

  typedef struct packed {
    logic [`AXI_AW-1:0]   awaddr;
    logic                 awvalid;
    logic [`AXI_DW-1:0]   wdata;
    logic [3:0]           wstrb;
    logic                 wvalid;
    logic                 bready;
    logic [`AXI_AW-1:0]   araddr;
    logic                 arvalid;
    logic                 rready;
  } axil_req_t;

  typedef struct packed {
    logic                 awready;
    logic                 wready;
    logic [1:0]           bresp;
    logic                 bvalid;
    logic                 arready;
    logic [`AXI_DW-1:0]   rdata;
    logic [1:0]           rresp;
    logic                 rvalid;
  } axil_rsp_t;

  typedef enum logic [1:0] {
    SW_IDLE,
    SW_DRAIN_OLD,
    SW_WAIT_NEW
  } switch_state_t;

  typedef struct packed {
    logic [3:0]           feedback_div;
    logic [3:0]           range_mult;
    logic                 loop_run;
    logic                 filter_track;
    logic                 source_is_vco;
  } loop_ctrl_out_t;

endpackage : pll_pkg

// File: rtl/pll_base_clock_selector.sv
// Purpose: loop control registers, lock flag and glitch-free base clock selector
// Assumes: crystal and vco clocks arrive as levels synchronous to i_sys_clk
// Notes:   base clock toggles on rising edges of the active source
//
// The register offsets and register access over AXI4-Lite were decided locally.
`timescale 1ns/1ns

// Operation
// - programming register: multiplier N in upper nibble, range L in lower nibble
// - N field zero drives the feedback divider like one
// - L field zero stops the loop and forces the crystal source
// - source change waits three old-source edges (sys cycles if leaving vco with the loop stopped) and three new-source edges, output held
// - selected source divided by two forms the base clock
// - base clock has 50 percent duty, half the source rate
// - vco source refused while loop enable is clear
// - one write never changes both loop enable and source select
// - select forced zero, read-only while enable clear or L zero
// - enable forced one and write-protected while select is one
// - irq enable forced zero, read-only while automatic mode off
// - lock flag and lock indicator read zero in manual mode
// - acquisition bit read-only in automatic mode, shows detector's mode
// - programming register ignores writes while loop enable is one
// - flag sets on each lock toggle in automatic mode; interrupt when flag and irq enable
// - a read of loop_control clears the lock flag unless a lock toggle sets it in the same cycle
// - reset sets enable, clears irq enable, flag and select
// - loop runs only while oscillator enable input is high
// - interrupt output comes from lock flag and irq enable
// - automatic bit read/write, one automatic, reset clears
// - lock indicator read-only, one when vco locked, reset clears
// - loop_control low four bits read as ones
module pll_base_clock_selector (
  input  wire logic                    i_sys_clk,
  input  wire logic                    i_rst,
  input  wire pll_pkg::axil_req_t      i_axi,
  output      pll_pkg::axil_rsp_t      o_axi,
  input  wire logic                    i_crystal_clock,
  input  wire logic                    i_vco_clock,
  input  wire logic                    i_oscillator_enable_in,
  input  wire logic                    i_lock_detect,
  input  wire logic                    i_track_detect,
  output      logic                    o_base_clock_out,
  output      logic                    o_clockgen_interrupt,
  output      pll_pkg::loop_ctrl_out_t o_loop
);
  import pll_pkg::*;

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic                 aw_got;
    logic [`AXI_AW-1:0]   aw_addr;
    logic                 w_got;
    logic [7:0]           w_data;
    logic                 w_lane0;
    logic                 bvalid;
    logic [1:0]           bresp;
    logic                 rvalid;
    logic [7:0]           rdata;
    logic [1:0]           rresp;
    logic                 irq_en;
    logic                 flag;
    logic                 enable;
    logic                 select;
    logic                 auto_bw;
    logic                 acq_man;
    logic                 lock;
    logic                 track;
    logic [3:0]           n_field;
    logic [3:0]           l_field;
    logic [1:0]           xs;
    logic [1:0]           vs;
    switch_state_t        sw;
    logic [1:0]           cnt;
    logic                 active_vco;
    logic                 base;
    logic                 irq;
  } state_t;

  state_t state_ff;
  state_t nxt_state;

  logic   x_rise;
  logic   v_rise;
  logic   act_rise;
  logic   old_rise;
  logic   new_rise;
  logic   want_vco;
  logic   do_wr;
  logic   do_rd;
  logic   wr_lc;
  logic   wr_bw;
  logic   wr_mp;
  logic   new_en;
  logic   new_sel;
  logic [7:0] lc_view;
  logic [7:0] bw_view;
  logic [7:0] mp_view;

  // ****************************************************************
  // register views
  // ****************************************************************
  always_comb
  begin
    lc_view = {state_ff.irq_en & state_ff.auto_bw,
               state_ff.flag & state_ff.auto_bw,
               state_ff.enable, state_ff.select, `LC_ONES};
    bw_view = {state_ff.auto_bw,
               state_ff.lock & state_ff.auto_bw,
               state_ff.auto_bw ? state_ff.track : state_ff.acq_man,
               5'h00};
    mp_view = {state_ff.n_field, state_ff.l_field};
  end

  // ****************************************************************
  // bus handshakes
  // ****************************************************************
  always_comb
  begin
    o_axi.awready = !state_ff.aw_got && !state_ff.bvalid;
    o_axi.wready  = !state_ff.w_got && !state_ff.bvalid;
    o_axi.bvalid  = state_ff.bvalid;
    o_axi.bresp   = state_ff.bresp;
    o_axi.arready = !state_ff.rvalid;
    o_axi.rvalid  = state_ff.rvalid;
    o_axi.rresp   = state_ff.rresp;
    o_axi.rdata   = {24'h000000, state_ff.rdata};
  end

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb
  begin
    nxt_state = state_ff;
    // address and data may arrive in either order
    if (i_axi.awvalid && o_axi.awready)
    begin
      nxt_state.aw_got  = 1'b1;
      nxt_state.aw_addr = i_axi.awaddr;
    end
    if (i_axi.wvalid && o_axi.wready)
    begin
      nxt_state.w_got   = 1'b1;
      nxt_state.w_data  = i_axi.wdata[7:0];
      nxt_state.w_lane0 = i_axi.wstrb[0];
    end
    if (state_ff.bvalid && i_axi.bready)
    begin
      nxt_state.bvalid = 1'b0;
    end
    do_wr = state_ff.aw_got && state_ff.w_got && !state_ff.bvalid;
    wr_lc = do_wr && state_ff.w_lane0 && (state_ff.aw_addr == `OFF_LOOP_CTRL);
    wr_bw = do_wr && state_ff.w_lane0 && (state_ff.aw_addr == `OFF_BW_CTRL);
    wr_mp = do_wr && state_ff.w_lane0 && (state_ff.aw_addr == `OFF_MUL_PROG);
    if (do_wr)
    begin
      nxt_state.aw_got = 1'b0;
      nxt_state.w_got  = 1'b0;
      nxt_state.bvalid = 1'b1;
      nxt_state.bresp  = ((state_ff.aw_addr == `OFF_LOOP_CTRL) || (state_ff.aw_addr == `OFF_BW_CTRL) ||
                          (state_ff.aw_addr == `OFF_MUL_PROG)) ? `RESP_OKAY : `RESP_SLVERR;
    end

    // read: data shows the state before this access
    do_rd = i_axi.arvalid && o_axi.arready;
    if (state_ff.rvalid && i_axi.rready)
    begin
      nxt_state.rvalid = 1'b0;
    end
    if (do_rd)
    begin
      nxt_state.rvalid = 1'b1;
      nxt_state.rresp  = `RESP_OKAY;
      case (i_axi.araddr)
        `OFF_LOOP_CTRL: nxt_state.rdata = lc_view;
        `OFF_BW_CTRL:   nxt_state.rdata = bw_view;
        `OFF_MUL_PROG:  nxt_state.rdata = mp_view;
        default:
        begin
          nxt_state.rdata = 8'h00;
          nxt_state.rresp = `RESP_SLVERR;
        end
      endcase
    end

    // loop_control
    new_en  = state_ff.enable;
    new_sel = state_ff.select;
    if (wr_lc)
    begin
      if (state_ff.auto_bw)
      begin
        nxt_state.irq_en = state_ff.w_data[`LC_IRQ_EN];
      end
      if (!state_ff.select)
      begin
        new_en = state_ff.w_data[`LC_ENABLE];
      end
      if (state_ff.enable && (state_ff.l_field != `MP_ZERO) && (new_en == state_ff.enable))
      begin
        new_sel = state_ff.w_data[`LC_SELECT];
      end
    end
    if (!state_ff.auto_bw)
    begin
      nxt_state.irq_en = 1'b0;
    end
    if (!new_en || (state_ff.l_field == `MP_ZERO))
    begin
      new_sel = 1'b0;
    end
    nxt_state.enable = new_en | new_sel;
    nxt_state.select = new_sel;

    // bandwidth_control
    if (wr_bw)
    begin
      nxt_state.auto_bw = state_ff.w_data[`BW_AUTO];
      if (!state_ff.auto_bw)
      begin
        nxt_state.acq_man = state_ff.w_data[`BW_ACQ];
      end
    end

    // multiplier_programming
    if (wr_mp && !state_ff.enable)
    begin
      nxt_state.n_field = state_ff.w_data[`MP_N_HI:`MP_N_LO];
      nxt_state.l_field = state_ff.w_data[`MP_L_HI:`MP_L_LO];
    end

    // lock detector; set wins over a read clear
    nxt_state.track = i_track_detect;
    nxt_state.lock  = state_ff.auto_bw ? i_lock_detect : 1'b0;
    if (do_rd && (i_axi.araddr == `OFF_LOOP_CTRL))
    begin
      nxt_state.flag = 1'b0;
    end
    if (state_ff.auto_bw && (nxt_state.lock != state_ff.lock))
    begin
      nxt_state.flag = 1'b1;
    end
    if (!state_ff.auto_bw)
    begin
      nxt_state.flag = 1'b0;
    end
    nxt_state.irq = nxt_state.flag & nxt_state.irq_en;

    // clock edge sampling
    nxt_state.xs = {state_ff.xs[0], i_crystal_clock};
    nxt_state.vs = {state_ff.vs[0], i_vco_clock};
    x_rise   = state_ff.xs[0] && !state_ff.xs[1];
    v_rise   = state_ff.vs[0] && !state_ff.vs[1];
    want_vco = state_ff.select && o_loop.loop_run;
    act_rise = state_ff.active_vco ? v_rise : x_rise;
    old_rise = act_rise;
    new_rise = state_ff.active_vco ? x_rise : v_rise;

    // transition control
    case (state_ff.sw)
      SW_IDLE:
      begin
        if (want_vco != state_ff.active_vco)
        begin
          nxt_state.sw  = SW_DRAIN_OLD;
          nxt_state.cnt = 2'h0;
        end
        else if (act_rise)
        begin
          nxt_state.base = !state_ff.base;
        end
      end
      SW_DRAIN_OLD:
      begin
        if (old_rise || (state_ff.active_vco && !o_loop.loop_run))
        begin
          nxt_state.cnt = state_ff.cnt + 2'h1;
          if (state_ff.cnt + 2'h1 == `SW_EDGES)
          begin
            nxt_state.sw  = SW_WAIT_NEW;
            nxt_state.cnt = 2'h0;
          end
        end
      end
      SW_WAIT_NEW:
      begin
        if (new_rise)
        begin
          nxt_state.cnt = state_ff.cnt + 2'h1;
          if (state_ff.cnt + 2'h1 == `SW_EDGES)
          begin
            nxt_state.sw         = SW_IDLE;
            nxt_state.active_vco = !state_ff.active_vco;
          end
        end
      end
      default:
      begin
        nxt_state.sw = SW_IDLE;
      end
    endcase
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  always_comb
  begin
    o_base_clock_out     = state_ff.base;
    o_clockgen_interrupt = state_ff.irq;
    o_loop.feedback_div  = (state_ff.n_field == `MP_ZERO) ? `MP_ONE : state_ff.n_field;
    o_loop.range_mult    = state_ff.l_field;
    o_loop.loop_run      = state_ff.enable && i_oscillator_enable_in &&
                           (state_ff.l_field != `MP_ZERO);
    o_loop.filter_track  = bw_view[`BW_ACQ];
    o_loop.source_is_vco = state_ff.active_vco;
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      state_ff         <= '0;
      state_ff.enable  <= 1'b1;
      state_ff.n_field <= `MP_FIELD_RST;
      state_ff.l_field <= `MP_FIELD_RST;
      state_ff.sw      <= SW_IDLE;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

endmodule : pll_base_clock_selector

// File: testbench/pll_base_clock_selector_checker.sv
// Purpose: port assertions of the base clock selector
// Assumes: sources slower than four sys cycles per phase
// Notes:   bound to every instance of the block
`timescale 1ns/1ns
`include "pll_defines.svh"
module pll_base_clock_selector_checker (
  input wire logic                    i_sys_clk,
  input wire logic                    i_rst,
  input wire pll_pkg::axil_req_t      i_axi,
  input wire pll_pkg::axil_rsp_t      o_axi,
  input wire logic                    i_oscillator_enable_in,
  input wire logic                    i_lock_detect,
  input wire logic                    o_base_clock_out,
  input wire logic                    o_clockgen_interrupt,
  input wire pll_pkg::loop_ctrl_out_t o_loop
);
  import pll_pkg::*;
  // ****************************************************************
  // helper counters
  // ****************************************************************
  logic [3:0] lock_quiet_ff;
  logic [7:0] base_quiet_ff;
  logic       lock_prev_ff;
  logic       base_prev_ff;
  always_ff @(posedge i_sys_clk)
  begin
    lock_prev_ff <= i_lock_detect;
    base_prev_ff <= o_base_clock_out;
    if (i_rst || i_lock_detect != lock_prev_ff)
      lock_quiet_ff <= 4'h0;
    else if (lock_quiet_ff != 4'hf)
      lock_quiet_ff <= lock_quiet_ff + 4'h1;
    if (i_rst || o_base_clock_out != base_prev_ff)
      base_quiet_ff <= 8'h0;
    else if (base_quiet_ff != 8'hff)
      base_quiet_ff <= base_quiet_ff + 8'h1;
  end
  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  sequence s_ctl_read;
    i_axi.arvalid && o_axi.arready && i_axi.araddr == `OFF_LOOP_CTRL && lock_quiet_ff >= 4'h4;
  endsequence
  a_reset_state: assert property (disable iff (1'b0) i_rst |=> !o_clockgen_interrupt &&
    !o_loop.source_is_vco && !o_base_clock_out && o_loop.range_mult == `MP_FIELD_RST)
    else $error("outputs not at reset state");
  a_div_nonzero: assert property (o_loop.feedback_div != 4'h0)
    else $error("feedback divider shows zero");
  a_run_gate: assert property (o_loop.loop_run |-> i_oscillator_enable_in && o_loop.range_mult != 4'h0)
    else $error("loop runs without enable or range");
  a_l_zero_xtal: assert property (o_loop.range_mult == 4'h0 |-> ##[0:150] !o_loop.source_is_vco)
    else $error("vco source kept with zero range");
  a_switch_hold: assert property ($changed(o_loop.source_is_vco) |-> $past(base_quiet_ff) >= 8'h07)
    else $error("base clock moved during source change");
  a_base_half: assert property ($changed(o_base_clock_out) |=> $stable(o_base_clock_out)[*6])
    else $error("base clock phase too short");
  a_base_alive: assert property (base_quiet_ff < 8'hc8)
    else $error("base clock stopped");
  a_read_clears: assert property (s_ctl_read |-> ##4 (!o_clockgen_interrupt || lock_quiet_ff < 4'h4))
    else $error("interrupt kept after control read");
endmodule : pll_base_clock_selector_checker

bind pll_base_clock_selector pll_base_clock_selector_checker u_chk (
  .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_axi(i_axi), .o_axi(o_axi),
  .i_oscillator_enable_in(i_oscillator_enable_in), .i_lock_detect(i_lock_detect),
  .o_base_clock_out(o_base_clock_out), .o_clockgen_interrupt(o_clockgen_interrupt), .o_loop(o_loop));

// File: testbench/sim_side_model.sv
// Purpose: far side: crystal source, base clock consumer
// Assumes: sources are levels stepped on the sys clock
// Notes:   base period measured between rising base edges
`timescale 1ns/1ns
module sim_side_model #(
  parameter int XTAL_HALF = 8,
  parameter int VCO_HALF  = 5
) (
  input  wire logic       i_sys_clk,
  input  wire logic       i_base_clock_out,
  output      logic       o_crystal_clock,
  output      logic [7:0] o_base_period
);
  // ****************************************************************
  // crystal source and period meter
  // ****************************************************************
  logic [7:0] xcnt_ff = 8'h0;
  logic [7:0] pcnt_ff = 8'h0;
  logic       prev_ff = 1'b0;
  initial o_crystal_clock = 1'b0;
  initial o_base_period = 8'h0;
  always @(posedge i_sys_clk)
  begin
    xcnt_ff <= (xcnt_ff == 8'(XTAL_HALF - 1)) ? 8'h0 : xcnt_ff + 8'h1;
    if (xcnt_ff == 8'(XTAL_HALF - 1))
      o_crystal_clock <= ~o_crystal_clock;
    prev_ff <= i_base_clock_out;
    pcnt_ff <= (i_base_clock_out && !prev_ff) ? 8'h1 : pcnt_ff + 8'h1;
    if (i_base_clock_out && !prev_ff)
      o_base_period <= pcnt_ff;
  end
endmodule : sim_side_model

// File: testbench/tb_pll_base_clock_selector.sv
// Purpose: self-checking bench of the base clock selector
// Assumes: crystal half period 8, vco half period 5 sys cycles
// Notes:   registers reached over the AXI4-Lite master tasks
`timescale 1ns/1ns
`include "pll_defines.svh"
module tb_pll_base_clock_selector;
  import pll_pkg::*;
  // ****************************************************************
  // signals and instances
  // ****************************************************************
  logic           clk = 1'b0;
  logic           rst, osc_en, lock, track, xtal, base, irq;
  logic           vco = 1'b0;
  logic [7:0]     per;
  logic [31:0]    rdat, seed, v;
  logic [1:0]     resp;
  axil_req_t      axi;
  axil_rsp_t      rsp;
  loop_ctrl_out_t lp;
  int             fails = 0;
  int             cmp_count = 0;
  always #5 clk = ~clk;
  always
  begin
    repeat (5) @(posedge clk);
    vco <= ~vco;
  end
  pll_base_clock_selector u_dut (.i_sys_clk(clk), .i_rst(rst), .i_axi(axi), .o_axi(rsp),
    .i_crystal_clock(xtal), .i_vco_clock(vco), .i_oscillator_enable_in(osc_en), .i_lock_detect(lock),
    .i_track_detect(track), .o_base_clock_out(base), .o_clockgen_interrupt(irq), .o_loop(lp));
  sim_side_model u_sim (.i_sys_clk(clk), .i_base_clock_out(base), .o_crystal_clock(xtal), .o_base_period(per));
  // ****************************************************************
  // tasks and functions
  // ****************************************************************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic [31:0] lc(input logic ie, input logic f, input logic en, input logic sel);
    return {24'h0, ie, f, en, sel, 4'hf};
  endfunction : lc
  task automatic stop_test(input bit hung);
    if (hung)
      fails++;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : stop_test
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("unexpected %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    axi.awaddr <= a;
    axi.wdata <= d;
    axi.awvalid <= 1'b1;
    axi.wvalid <= 1'b1;
    axi.bready <= 1'b1;
    for (n = 0; n < 40; n++)
    begin
      @(posedge clk);
      if (rsp.awready) axi.awvalid <= 1'b0;
      if (rsp.wready) axi.wvalid <= 1'b0;
      if (rsp.bvalid) break;
    end
    axi.bready <= 1'b0;
    resp = rsp.bresp;
    if (n == 40) stop_test(1);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    int n;
    @(posedge clk);
    axi.araddr <= a;
    axi.arvalid <= 1'b1;
    axi.rready <= 1'b1;
    for (n = 0; n < 40; n++)
    begin
      @(posedge clk);
      if (rsp.arready) axi.arvalid <= 1'b0;
      if (rsp.rvalid) break;
    end
    axi.rready <= 1'b0;
    rdat = rsp.rdata;
    resp = rsp.rresp;
    if (n == 40) stop_test(1);
  endtask : rd
  task automatic await(input bit src, input logic val);
    int n;
    for (n = 0; n < 250; n++)
    begin
      @(posedge clk);
      if ((src ? lp.source_is_vco : irq) === val) break;
    end
    if (n == 250) stop_test(1);
  endtask : await
  task automatic settle();
    int n, k;
    logic b;
    k = 0;
    for (n = 0; n < 300 && k < 3; n++)
    begin
      b = base;
      @(posedge clk);
      if (base && !b) k++;
    end
    if (k < 3) stop_test(1);
  endtask : settle
  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial
  begin
    rst = 1'b1;
    axi = '0;
    axi.wstrb = 4'hf;
    osc_en = 1'b1;
    lock = 1'b0;
    track = 1'b0;
    seed = 32'hb718;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rd(`OFF_LOOP_CTRL); chk("ctl", rdat, lc(0, 0, 1, 0));
    rd(`OFF_BW_CTRL); chk("bw", rdat, 32'h0);
    rd(`OFF_MUL_PROG); chk("mul", rdat, 32'h66);
    wr(`OFF_MUL_PROG, 32'h12); rd(`OFF_MUL_PROG); chk("mul", rdat, 32'h66);
    $display("test reset done");
    wr(`OFF_LOOP_CTRL, lc(0, 0, 0, 0)); rd(`OFF_LOOP_CTRL); chk("ctl", rdat, lc(0, 0, 0, 0));
    for (int i = 0; i < 6; i++)
    begin
      v = (i < 2) ? {24'h0, 4'(i), 4'h3} : {24'h0, seed[7:0]};
      seed = lfsr(seed);
      wr(`OFF_MUL_PROG, v); rd(`OFF_MUL_PROG); chk("mul", rdat, v);
      chk("div", lp.feedback_div, (v[7:4] == 4'h0) ? 32'h1 : v[7:4]);
      chk("range", lp.range_mult, v[3:0]);
    end
    wr(`OFF_MUL_PROG, 32'h60); wr(`OFF_LOOP_CTRL, lc(0, 0, 1, 0)); wr(`OFF_LOOP_CTRL, lc(0, 0, 1, 1));
    rd(`OFF_LOOP_CTRL); chk("ctl", rdat, lc(0, 0, 1, 0));
    chk("run", lp.loop_run, 32'h0);
    wr(`OFF_LOOP_CTRL, lc(0, 0, 0, 0)); wr(`OFF_MUL_PROG, 32'h66);
    wr(`OFF_LOOP_CTRL, lc(0, 0, 1, 1)); rd(`OFF_LOOP_CTRL); chk("ctl", rdat, lc(0, 0, 1, 0));
    chk("run", lp.loop_run, 32'h1);
    osc_en <= 1'b0;
    @(posedge clk); chk("run", lp.loop_run, 32'h0);
    osc_en <= 1'b1;
    settle(); chk("xtal period", per, 32'd32);
    wr(`OFF_LOOP_CTRL, lc(0, 0, 1, 1)); rd(`OFF_LOOP_CTRL); chk("ctl", rdat, lc(0, 0, 1, 1));
    await(1, 1);
    settle(); chk("vco period", per, 32'd20);
    wr(`OFF_LOOP_CTRL, lc(0, 0, 0, 1)); rd(`OFF_LOOP_CTRL); chk("ctl", rdat, lc(0, 0, 1, 1));
    wr(`OFF_LOOP_CTRL, lc(0, 0, 1, 0)); await(1, 0);
    $display("test select done");
    wr(`OFF_LOOP_CTRL, lc(1, 0, 1, 0)); rd(`OFF_LOOP_CTRL); chk("ctl", rdat, lc(0, 0, 1, 0));
    wr(`OFF_BW_CTRL, 32'h20); rd(`OFF_BW_CTRL); chk("bw", rdat, 32'h20);
    chk("track", lp.filter_track, 32'h1);
    lock <= 1'b1;
    track <= seed[3];
    rd(`OFF_BW_CTRL); chk("bw", rdat, 32'h20);
    rd(`OFF_LOOP_CTRL); chk("ctl", rdat, lc(0, 0, 1, 0));
    wr(`OFF_BW_CTRL, 32'h80); rd(`OFF_BW_CTRL); chk("bw", rdat, {24'h0, 2'b11, track, 5'h0});
    wr(`OFF_BW_CTRL, {24'h0, 2'b10, ~track, 5'h0}); rd(`OFF_BW_CTRL);
    chk("bw", rdat, {24'h0, 2'b11, track, 5'h0});
    chk("irq", irq, 32'h0);
    rd(`OFF_LOOP_CTRL); chk("ctl", rdat, lc(0, 1, 1, 0));
    rd(`OFF_LOOP_CTRL); chk("ctl", rdat, lc(0, 0, 1, 0));
    wr(`OFF_LOOP_CTRL, lc(1, 0, 1, 0)); rd(`OFF_LOOP_CTRL); chk("ctl", rdat, lc(1, 0, 1, 0));
    lock <= 1'b0;
    await(0, 1);
    rd(`OFF_LOOP_CTRL); chk("ctl", rdat, lc(1, 1, 1, 0));
    await(0, 0);
    $display("test lock done");
    rd(8'h0c); chk("rresp", resp, 32'h2);
    wr(8'h0c, 32'h0); chk("bresp", resp, 32'h2);
    $display("test unmapped done");
    stop_test(0);
  end
endmodule : tb_pll_base_clock_selector
